// *** dual_gpio_regs.vh ***
`ifndef DUAL_GPIO_REGS_VH
`define DUAL_GPIO_REGS_VH
// Register byte addresses (word aligned, classic Wishbone)
`define ADDR_FIRST_DATA 8'h00
`define ADDR_FIRST_DIR 8'h04
`define ADDR_SECOND_DATA 8'h08
`define ADDR_SECOND_DIR 8'h0C
`define ADDR_ANALOG_SEL 8'h10
`define ADDR_SEG_TWO 8'h14
`define ADDR_SEG_THREE 8'h18
`define ADDR_SEG_FOUR 8'h1C
`define ADDR_STATUS 8'h20
// Reset values
`define DIR_RESET 8'hFF
`define ANALOG_RESET 8'hFF
`define SEG_RESET 8'h00
`define DATA_RESET 8'h00
// Variant codes
`define VARIANT_SMALL 2'd0
`define VARIANT_MID 2'd1
`define VARIANT_LARGE 2'd2
// Field positions
`define INPUT_ONLY_BIT 3
`define LOW_MASK 8'h07
`define HIGH_MASK 8'hF0
`define BIT3_MASK 8'h08
`define FULL_MASK 8'hFF
// Segment bits: group two bits 7:5 for pins 0..2; group three 7:0 for first 7:4 and second 7:4
`define SEG2_LSB 5
`endif

// *** pin_sync.v ***
// Two-flop synchroniser for a bank of pin inputs
module pin_sync #(
  parameter WIDTH = 8
) (
  input wire clk, // System clock
  input wire arst_n, // Asynchronous reset, active low
  input wire [WIDTH-1:0] async_in, // Raw pin levels
  output reg [WIDTH-1:0] sync_out // Synchronised levels
);
  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // pin_sync

// *** dual_gpio_port_e_f.v ***
// The Wishbone slave port and the register addresses were decided locally.
`include "dual_gpio_regs.vh"
module dual_gpio_port_e_f #(
  parameter [1:0] VARIANT = 2'd2 // 0 small, 1 mid, 2 large
) (
  input wire clk, // 40 MHz system clock
  input wire arst_n, // Any reset, active low
  input wire por_n, // Power-on or brown-out reset, active low
  input wire master_clear_enable_setting, // Configuration: pin 3 is reset
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire [7:0] first_port_in, // First port pin levels
  output reg [7:0] first_port_out, // First port output values
  output reg [7:0] first_port_oe_n, // First port drive enable, low drives
  input wire [7:0] second_port_in, // Second port pin levels
  output reg [7:0] second_port_out, // Second port output values
  output reg [7:0] second_port_oe_n, // Second port drive enable, low drives
  output wire master_clear_input, // Pin 3 level as reset request, active low
  output wire master_clear_pullup, // Weak pull-up enable on pin 3
  output wire [2:0] converter_analog_input, // Analog routing for pins 0..2
  output wire [7:0] first_lcd_segment_output, // Segment owns first port pin
  output wire [7:0] second_lcd_segment_output // Segment owns second port pin
);

  // Variant masks of implemented bits
  function [7:0] first_impl;
    input [1:0] v;
    begin
      first_impl = `BIT3_MASK;
      if (v != `VARIANT_SMALL) first_impl = first_impl | `LOW_MASK;
      if (v == `VARIANT_LARGE) first_impl = first_impl | `HIGH_MASK;
    end
  endfunction

  function [7:0] second_impl;
    input [1:0] v;
    begin
      second_impl = (v == `VARIANT_LARGE) ? `FULL_MASK : 8'h00;
    end
  endfunction

  // Byte-lane merge for a write into an 8-bit register
  function [7:0] lane0;
    input [7:0] old;
    input [3:0] sel;
    input [31:0] dat;
    begin
      lane0 = sel[0] ? dat[7:0] : old;
    end
  endfunction

  // Address compare shared by every write strobe
  function addr_hit;
    input [7:0] adr;
    input [7:0] target;
    begin
      addr_hit = (adr == target);
    end
  endfunction

  localparam [7:0] FIRST_MASK = first_impl(VARIANT);
  localparam [7:0] SECOND_MASK = second_impl(VARIANT);

  reg [7:0] first_port_data;
  reg [7:0] first_port_direction;
  reg [7:0] second_port_data;
  reg [7:0] second_port_direction;
  reg [7:0] analog_pin_select;
  reg [7:0] segment_enable_group_two;
  reg [7:0] segment_enable_group_three;
  reg [7:0] segment_enable_group_four;
  wire [7:0] first_sync;
  wire [7:0] second_sync;
  wire req;
  wire wr;
  wire wr_first_data;
  wire wr_first_dir;
  wire wr_second_data;
  wire wr_second_dir;
  wire wr_analog_sel;
  wire wr_seg_two;
  wire wr_seg_three;
  wire wr_seg_four;
  wire [7:0] first_alt;
  wire [7:0] second_alt;
  wire [7:0] first_dir_view;
  wire [7:0] first_read;
  wire [7:0] second_read;
  reg [31:0] next_rdata;

  // Pins come from outside the clock domain
  pin_sync #(.WIDTH(8)) u_first_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(first_port_in),
    .sync_out(first_sync)
  );

  pin_sync #(.WIDTH(8)) u_second_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(second_port_in),
    .sync_out(second_sync)
  );

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;

  // Write strobes, one per writable register; unmapped addresses hit none, so a stray write is dropped
  assign wr_first_data = wr & addr_hit(wb_adr_i, `ADDR_FIRST_DATA);
  assign wr_first_dir = wr & addr_hit(wb_adr_i, `ADDR_FIRST_DIR);
  assign wr_second_data = wr & addr_hit(wb_adr_i, `ADDR_SECOND_DATA);
  assign wr_second_dir = wr & addr_hit(wb_adr_i, `ADDR_SECOND_DIR);
  assign wr_analog_sel = wr & addr_hit(wb_adr_i, `ADDR_ANALOG_SEL);
  assign wr_seg_two = wr & addr_hit(wb_adr_i, `ADDR_SEG_TWO);
  assign wr_seg_three = wr & addr_hit(wb_adr_i, `ADDR_SEG_THREE);
  assign wr_seg_four = wr & addr_hit(wb_adr_i, `ADDR_SEG_FOUR);

  // Pin ownership by alternate functions
  assign converter_analog_input = analog_pin_select[2:0] & FIRST_MASK[2:0];
  assign first_lcd_segment_output = FIRST_MASK & {segment_enable_group_three[3:0], 1'b0,
    segment_enable_group_two[7:`SEG2_LSB]};
  assign second_lcd_segment_output = SECOND_MASK &
    {segment_enable_group_three[7:4], segment_enable_group_four[3:0]};
  assign first_alt = first_lcd_segment_output | {5'b0_0000, converter_analog_input};
  assign second_alt = second_lcd_segment_output;

  // Pin 3 never drives; its view is forced to input
  assign first_dir_view = (first_port_direction | `BIT3_MASK) & FIRST_MASK;

  // Reads see pin level; alternate-owned and absent bits read zero
  assign first_read = first_sync & FIRST_MASK & ~first_alt &
    ~(master_clear_enable_setting ? `BIT3_MASK : 8'h00);
  assign second_read = second_sync & SECOND_MASK & ~second_alt;

  // Reset function of pin 3 with its pull-up
  assign master_clear_input = master_clear_enable_setting ? first_sync[`INPUT_ONLY_BIT] : 1'b1;
  assign master_clear_pullup = master_clear_enable_setting;

  // Output latches on any reset; contents are don't-care, zero chosen
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_port_data <= `DATA_RESET;
      second_port_data <= `DATA_RESET;
    end else begin
      if (wr_first_data) begin
        first_port_data <= lane0(first_port_data, wb_sel_i, wb_dat_i);
      end
      if (wr_second_data) begin
        second_port_data <= lane0(second_port_data, wb_sel_i, wb_dat_i);
      end
    end
  end

  // Directions start as inputs so no pin fights the board after reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_port_direction <= `DIR_RESET;
      second_port_direction <= `DIR_RESET;
    end else begin
      if (wr_first_dir) begin
        first_port_direction <= lane0(first_port_direction, wb_sel_i, wb_dat_i);
      end
      if (wr_second_dir) begin
        second_port_direction <= lane0(second_port_direction, wb_sel_i, wb_dat_i);
      end
    end
  end

  // Analog selection comes out of reset owning its pins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_pin_select <= `ANALOG_RESET;
    end else if (wr_analog_sel) begin
      analog_pin_select <= lane0(analog_pin_select, wb_sel_i, wb_dat_i);
    end
  end

  // Segment enables survive all but power resets
  // Separate reset net: a plain reset must not blank the display
  always @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      segment_enable_group_two <= `SEG_RESET;
      segment_enable_group_three <= `SEG_RESET;
      segment_enable_group_four <= `SEG_RESET;
    end else begin
      if (wr_seg_two) begin
        segment_enable_group_two <= lane0(segment_enable_group_two, wb_sel_i, wb_dat_i);
      end
      if (wr_seg_three) begin
        segment_enable_group_three <= lane0(segment_enable_group_three, wb_sel_i, wb_dat_i);
      end
      if (wr_seg_four) begin
        segment_enable_group_four <= lane0(segment_enable_group_four, wb_sel_i, wb_dat_i);
      end
    end
  end

  // Read mux; unmapped addresses read zero and still ack
  always @* begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `ADDR_FIRST_DATA: next_rdata = {24'h00_0000, first_read};
      `ADDR_FIRST_DIR: next_rdata = {24'h00_0000, first_dir_view};
      `ADDR_SECOND_DATA: next_rdata = {24'h00_0000, second_read};
      `ADDR_SECOND_DIR: next_rdata = {24'h00_0000, second_port_direction & SECOND_MASK};
      `ADDR_ANALOG_SEL: next_rdata = {24'h00_0000, analog_pin_select};
      `ADDR_SEG_TWO: next_rdata = {24'h00_0000, segment_enable_group_two};
      `ADDR_SEG_THREE: next_rdata = {24'h00_0000, segment_enable_group_three};
      `ADDR_SEG_FOUR: next_rdata = {24'h00_0000, segment_enable_group_four};
      `ADDR_STATUS: next_rdata = {16'h0000, first_alt, second_alt};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // One wait state: ack one cycle after request, dropped next cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // First port drivers registered; alternate function wins over the latch
  // Registering costs one edge of latency but keeps pins glitch free
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_port_out <= `DATA_RESET;
      first_port_oe_n <= `FULL_MASK;
    end else begin
      first_port_out <= first_port_data & FIRST_MASK & ~first_alt;
      first_port_oe_n <= first_dir_view | first_alt;
    end
  end

  // Second port drivers; absent bits never drive on smaller variants
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_port_out <= `DATA_RESET;
      second_port_oe_n <= `FULL_MASK;
    end else begin
      second_port_out <= second_port_data & SECOND_MASK & ~second_alt;
      second_port_oe_n <= (second_port_direction & SECOND_MASK) | ~SECOND_MASK | second_alt;
    end
  end
endmodule // dual_gpio_port_e_f

// *** gpio_checker_sva.sv ***
`include "dual_gpio_regs.vh"
module gpio_checker (
  input wire clk, // Clock
  input wire arst_n, // Reset
  input wire master_clear_enable_setting, // Config
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write
  input wire [7:0] wb_adr_i, // Address
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Ack
  input wire [7:0] first_port_oe_n, // Drive off
  input wire [7:0] second_port_oe_n, // Drive off
  input wire master_clear_input, // Reset request
  input wire master_clear_pullup, // Pull-up
  input wire [2:0] converter_analog_input, // Analog owns
  input wire [7:0] first_lcd_segment_output, // Segment owns
  input wire [7:0] second_lcd_segment_output // Segment owns
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Request taken, then a single-cycle answer
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_rd; wb_ack_o && !wb_we_i; endsequence
  AST_ACK: assert property (s_req |=> s_ans) else $error("ack not one cycle after request");
  AST_BIT3_NODRV: assert property (first_port_oe_n[3]) else $error("input-only pin driven");
  AST_PULLUP: assert property (master_clear_pullup == master_clear_enable_setting) else $error("pull-up wrong");
  AST_MASTER_CLEAR_INPUT_OFF: assert property (!master_clear_enable_setting |-> master_clear_input) else $error("reset asserted");
  AST_DIR_RST: assert property ($rose(arst_n) |-> (first_port_oe_n & second_port_oe_n) == 8'hFF) else $error("dir rst");
  // Drive enables follow owner bits one edge later, hence past
  AST_SEG_FIRST: assert property (($past(first_lcd_segment_output) & ~first_port_oe_n) == 8'h00) else $error("seg1 drv");
  AST_SEG_SECOND: assert property (($past(second_lcd_segment_output) & ~second_port_oe_n) == 8'h00) else $error("seg2");
  AST_ANALOG: assert property (($past(converter_analog_input) & ~first_port_oe_n[2:0]) == 3'h0) else $error("analog");
  AST_MASTER_CLEAR_INPUT_RD: assert property (s_rd ##0 wb_adr_i == `ADDR_FIRST_DATA && master_clear_enable_setting
    |-> !wb_dat_o[3]) else $error("pin 3 read while reset pin");
  AST_DIR3_RD: assert property (s_rd ##0 wb_adr_i == `ADDR_FIRST_DIR |-> wb_dat_o[3]) else $error("dir bit 3");
endmodule // gpio_checker
bind dual_gpio_port_e_f gpio_checker gpio_checker_inst (.clk, .arst_n, .master_clear_enable_setting, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .first_port_oe_n, .second_port_oe_n, .master_clear_input,
  .master_clear_pullup, .converter_analog_input, .first_lcd_segment_output, .second_lcd_segment_output);

// *** pin_model.sv ***
module pin_model (
  input wire [7:0] first_out, // Latch
  input wire [7:0] first_oe_n, // Drive off
  input wire [7:0] first_ext, // Outside level
  output wire [7:0] first_pin, // Pin level
  input wire [7:0] second_out, // Latch
  input wire [7:0] second_oe_n, // Drive off
  input wire [7:0] second_ext, // Outside level
  output wire [7:0] second_pin // Pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven bits show the latch, released bits the outside world
  assign first_pin = (first_out & ~first_oe_n) | (first_ext & first_oe_n);
  assign second_pin = (second_out & ~second_oe_n) | (second_ext & second_oe_n);
endmodule // pin_model

// *** dual_gpio_port_e_f_tb.sv ***
module dual_gpio_port_e_f_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, por_n = 0, mcen = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00, q, first_ext = 8'h00, second_ext = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  wire [31:0] rdat;
  wire ack, mci, pu;
  wire [2:0] conv;
  wire [7:0] f_in, f_out, f_oe, s_in, s_out, s_oe;
  int fails = 0, tests_run = 0;
  initial forever #12.5 clk = ~clk;
  dual_gpio_port_e_f dual_gpio_port_e_f_inst (.clk(clk), .arst_n(arst_n), .por_n(por_n),
    .master_clear_enable_setting(mcen), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .first_port_in(f_in),
    .first_port_out(f_out), .first_port_oe_n(f_oe), .second_port_in(s_in), .second_port_out(s_out),
    .second_port_oe_n(s_oe), .master_clear_input(mci), .master_clear_pullup(pu), .converter_analog_input(conv),
    .first_lcd_segment_output(), .second_lcd_segment_output());
  pin_model pin_model_inst (.first_out(f_out), .first_oe_n(f_oe), .first_ext(first_ext), .first_pin(f_in),
    .second_out(s_out), .second_oe_n(s_oe), .second_ext(second_ext), .second_pin(s_in));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Extra edges let the pin synchroniser settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic reset(input logic pwr);
    @(posedge clk);
    arst_n <= 1'b0;
    por_n <= ~pwr;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Whole run is under two hundred cycles
  initial begin
    #50us;
    fails++;
    print_verdict();
  end
  initial begin
    reset(1'b1);
    rd(8'h04, 8'hFF);
    rd(8'h0C, 8'hFF);
    rd(8'h10, 8'hFF);
    rd(8'h18, 8'h00);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h08);
    wr(8'h10, 8'h00);
    first_ext <= 8'h08;
    wr(8'h00, 8'hA5);
    chk("first oe_n", f_oe, 8'h08);
    chk("first out", f_out, 8'hA5);
    rd(8'h00, 8'hAD);
    mcen <= 1'b1;
    rd(8'h00, 8'hA5);
    wr(8'h10, 8'h07);
    rd(8'h00, 8'hA0);
    chk("first oe_n", f_oe, 8'h0F);
    chk("first out", f_out, 8'hA0);
    chk("analog owns", {5'h00, conv}, 8'h07);
    wr(8'h10, 8'h00);
    wr(8'h0C, 8'h0F);
    second_ext <= 8'h96;
    wr(8'h08, 8'h3C);
    rd(8'h08, 8'h36);
    chk("second out", s_out, 8'h3C);
    wr(8'h18, 8'hFF);
    rd(8'h00, 8'h05);
    rd(8'h08, 8'h06);
    chk("second oe_n", s_oe, 8'hFF);
    wr(8'h14, 8'hE0);
    rd(8'h00, 8'h00);
    wr(8'h1C, 8'h0F);
    rd(8'h08, 8'h00);
    rd(8'h20, 8'hFF);
    rd(8'h24, 8'h00);
    first_ext <= 8'h00;
    repeat (4) @(posedge clk);
    chk("reset request", {7'h00, mci}, 8'h00);
    chk("pull-up", {7'h00, pu}, 8'h01);
    reset(1'b0);
    rd(8'h18, 8'hFF);
    rd(8'h04, 8'hFF);
    reset(1'b1);
    rd(8'h18, 8'h00);
    print_verdict();
  end
endmodule // dual_gpio_port_e_f_tb
